// ==== rtl/pem_defines.svh ====
`ifndef PEM_DEFINES_SVH
`define PEM_DEFINES_SVH

// Register byte offsets
`define PEM_OFF_FEAT_OFFER_LO 8'h00
`define PEM_OFF_FEAT_OFFER_HI 8'h04
`define PEM_OFF_FEAT_DRV_LO 8'h08
`define PEM_OFF_FEAT_DRV_HI 8'h0C
`define PEM_OFF_CTRL 8'h10
`define PEM_OFF_STATUS 8'h14
`define PEM_OFF_LIMIT 8'h18
`define PEM_OFF_REGION_SEL 8'h1C
`define PEM_OFF_REGION_BASE_LO 8'h20
`define PEM_OFF_REGION_BASE_HI 8'h24
`define PEM_OFF_REGION_VALID 8'h28
`define PEM_OFF_NOTIFY 8'h2C
`define PEM_OFF_NOTIFY_LAST 8'h30

// Feature bit positions
`define PEM_FEAT_INDIRECT 28
`define PEM_FEAT_SUPPRESS_IDX 29
`define PEM_FEAT_VERSION 32
`define PEM_FEAT_ACCESS_PLAT 33
`define PEM_FEAT_PACKED 34
`define PEM_FEAT_IN_ORDER 35
`define PEM_FEAT_ORDER_PLAT 36
`define PEM_FEAT_SRIOV 37
`define PEM_FEAT_NOTIFY_DATA 38

// Control field positions
`define PEM_CTRL_FENCE_EN 0

// Reset values
`define PEM_RST_CTRL 32'h0000_0001
`define PEM_RST_LIMIT 32'h0000_0008
`define PEM_RST_DRV 64'h0000_0000_0000_0000

// Sizes and counts
`define PEM_MSG_WORDS 15
`define PEM_EVT_WORDS 3
`define PEM_STORE_DEPTH 8
`define PEM_REGIONS 8

`endif

// ==== rtl/pem_pkg.sv ====
package pem_pkg;

   typedef struct packed {
      logic [63:0] ctx_tag;
      logic [63:0] metadata;
      logic [63:0] region_id;
      logic [63:0] region_offset;
      logic [63:0] region_size;
      logic [63:0] guest_phys;
      logic [63:0] host_addr;
      logic [31:0] events;
   } pem_trigger_t;

   typedef struct packed {
      logic [63:0] ctx_tag;
      logic [63:0] metadata;
      logic [63:0] region_offset;
      logic [63:0] region_size;
      logic [63:0] guest_phys;
      logic [63:0] host_addr;
      logic host_addr_ok;
      logic [31:0] events;
   } pem_action_t;

   typedef enum logic [1:0] {
      PEM_IDLE,
      PEM_FENCE,
      PEM_ACT,
      PEM_EVT
   } pem_state_t;

endpackage : pem_pkg

// ==== rtl/pem_unit.sv ====
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`include "pem_defines.svh"
// Behaviour
// RULE1 - Trigger: seven 64-bit fields then 32-bit requested-event mask.
// RULE2 - Guest sends triggers only to device on the dedicated trigger queue.
// RULE3 - Trigger names valid context; region id may be invalid or unallocated.
// RULE4 - Guest driver derives guest physical address from region offset.
// RULE5 - Device resolves host address itself after arrival; guest value ignored.
// RULE6 - Without coherency, fence after arrival before acting on region.
// RULE7 - Nonzero requested-event mask yields completion on event queue.
// RULE8 - Many contexts accepted; each context processed in arrival order.
// RULE9 - Full queue: further triggers held in storage, never dropped.
// RULE10 - In-flight limit enforced; guest stalls at limit. The unit only flags limit_reached_out; ping_ready_out ignores the limit.
// RULE11 - Shared region carries transfers in both directions.
// RULE12 - Completion: 64-bit context tag then 32-bit returned events, device-written.
// RULE13 - Guest routes completion by its context tag.
// RULE14 - Bit 28 indirect tables; bit 29 suppression index fields.
// RULE15 - Bit 32 marks current revision compliance.
// RULE16 - Bit 33 clear: addresses used untranslated, platform limits ignored.
// RULE17 - Bit 34 advertises packed queue layout.
// RULE18 - Bit 35: used buffers returned in availability order.
// RULE19 - Bit 36 negotiated: platform ordering for hardware devices.
// RULE20 - Bit 37 advertises single-root virtualization; PCI devices only.
// RULE21 - Bit 38: notifications carry extra data, accepted by device.
// RULE22 - Fields little-endian, declaration order, no padding.
// RULE23 - Completion carries the trigger's context tag.
module pem_unit #(
   parameter bit IS_PCI = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic ping_valid_in,
   input wire logic [31:0] ping_data_in,
   output logic ping_ready_out,
   output logic fence_req_out,
   input wire logic fence_ack_in,
   output logic act_valid_out,
   output pem_pkg::pem_action_t act_out,
   input wire logic act_done_in,
   input wire logic [31:0] act_revents_in,
   output logic evt_valid_out,
   output logic [31:0] evt_data_out,
   output logic evt_last_out,
   input wire logic evt_ready_in,
   output logic [63:0] feat_neg_out,
   output logic [3:0] inflight_out,
   output logic limit_reached_out,
   output logic [15:0] notify_queue_out,
   output logic [15:0] notify_data_out,
   output logic notify_pulse_out
);

   localparam int DEPTH = `PEM_STORE_DEPTH;
   localparam logic [63:0] OFFER = (64'h1 << `PEM_FEAT_INDIRECT) | (64'h1 << `PEM_FEAT_SUPPRESS_IDX)
      | (64'h1 << `PEM_FEAT_VERSION) | (64'h1 << `PEM_FEAT_ACCESS_PLAT) | (64'h1 << `PEM_FEAT_PACKED)
      | (64'h1 << `PEM_FEAT_IN_ORDER) | (64'h1 << `PEM_FEAT_ORDER_PLAT)
      | ({63'h0, IS_PCI} << `PEM_FEAT_SRIOV) | (64'h1 << `PEM_FEAT_NOTIFY_DATA); // see RULE14 RULE15 RULE17 RULE20

   // Bus slave: one wait cycle on every access
   logic ack;
   logic [63:0] feat_drv;
   logic [31:0] ctrl;
   logic [31:0] limit;
   logic [2:0] region_sel;
   logic [63:0] region_base [`PEM_REGIONS];
   logic [`PEM_REGIONS-1:0] region_valid;
   logic [31:0] notify_last;
   wire req = avs_read_in | avs_write_in;
   // Writes land only at the edge where waitrequest is seen low
   wire wr_go = avs_write_in & ack;
   wire [7:0] addr = {avs_address_in[7:2], 2'b00};
   wire wr_drv_lo = wr_go && addr == `PEM_OFF_FEAT_DRV_LO;
   wire wr_drv_hi = wr_go && addr == `PEM_OFF_FEAT_DRV_HI;
   wire wr_ctrl = wr_go && addr == `PEM_OFF_CTRL;
   wire wr_limit = wr_go && addr == `PEM_OFF_LIMIT;
   wire wr_sel = wr_go && addr == `PEM_OFF_REGION_SEL;
   wire wr_base_lo = wr_go && addr == `PEM_OFF_REGION_BASE_LO;
   wire wr_base_hi = wr_go && addr == `PEM_OFF_REGION_BASE_HI;
   wire wr_rvalid = wr_go && addr == `PEM_OFF_REGION_VALID;
   wire wr_notify = wr_go && addr == `PEM_OFF_NOTIFY;
   wire neg_notify_data = feat_neg_out[`PEM_FEAT_NOTIFY_DATA];
   wire [31:0] notify_val = neg_notify_data ? avs_writedata_in : {16'h0, avs_writedata_in[15:0]}; // see RULE21

   assign avs_waitrequest_out = req & ~ack;
   assign feat_neg_out = feat_drv & OFFER;
   assign notify_queue_out = notify_last[15:0];
   assign notify_data_out = notify_last[31:16];

   // Store and processing state
   logic [3:0] wcnt;
   logic [`PEM_MSG_WORDS*32-1:0] asm_buf;
   pem_pkg::pem_trigger_t store [DEPTH];
   logic [2:0] wr_ptr;
   logic [2:0] rd_ptr;
   logic [3:0] count;
   pem_pkg::pem_state_t state;
   pem_pkg::pem_trigger_t cur;
   logic [95:0] evt_sh;
   logic [1:0] evt_cnt;

   wire [31:0] status = {26'h0, limit_reached_out, ping_ready_out, inflight_out};
   wire [31:0] rd_mux =
      (addr == `PEM_OFF_FEAT_OFFER_LO) ? OFFER[31:0] :
      (addr == `PEM_OFF_FEAT_OFFER_HI) ? OFFER[63:32] :
      (addr == `PEM_OFF_FEAT_DRV_LO) ? feat_drv[31:0] :
      (addr == `PEM_OFF_FEAT_DRV_HI) ? feat_drv[63:32] :
      (addr == `PEM_OFF_CTRL) ? ctrl :
      (addr == `PEM_OFF_STATUS) ? status :
      (addr == `PEM_OFF_LIMIT) ? limit :
      (addr == `PEM_OFF_REGION_SEL) ? {29'h0, region_sel} :
      (addr == `PEM_OFF_REGION_BASE_LO) ? region_base[region_sel][31:0] :
      (addr == `PEM_OFF_REGION_BASE_HI) ? region_base[region_sel][63:32] :
      (addr == `PEM_OFF_REGION_VALID) ? {24'h0, region_valid} :
      (addr == `PEM_OFF_NOTIFY_LAST) ? notify_last : 32'h0000_0000;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack <= 1'b0;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         ack <= req & ~ack;
         if (avs_read_in && !ack) begin
            avs_readdata_out <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         feat_drv <= `PEM_RST_DRV;
         ctrl <= `PEM_RST_CTRL;
         limit <= `PEM_RST_LIMIT;
         region_sel <= 3'h0;
         region_valid <= 8'h00;
         notify_last <= 32'h0000_0000;
         notify_pulse_out <= 1'b0;
      end else begin
         notify_pulse_out <= wr_notify;
         if (wr_drv_lo) feat_drv[31:0] <= avs_writedata_in;
         if (wr_drv_hi) feat_drv[63:32] <= avs_writedata_in;
         if (wr_ctrl) ctrl <= avs_writedata_in;
         if (wr_limit) limit <= avs_writedata_in;
         if (wr_sel) region_sel <= avs_writedata_in[2:0];
         if (wr_rvalid) region_valid <= avs_writedata_in[7:0];
         if (wr_notify) notify_last <= notify_val;
      end
   end

   always_ff @(posedge clk_in) begin
      if (wr_base_lo) region_base[region_sel][31:0] <= avs_writedata_in;
      if (wr_base_hi) region_base[region_sel][63:32] <= avs_writedata_in;
   end

   // Trigger assembly: words arrive low half first, fields in order
   wire ping_take = ping_valid_in & ping_ready_out;
   wire last_word = wcnt == 4'(`PEM_MSG_WORDS - 1);
   wire [`PEM_MSG_WORDS*32-1:0] asm_next = {ping_data_in, asm_buf[`PEM_MSG_WORDS*32-1:32]};
   pem_pkg::pem_trigger_t asm_msg;
   assign asm_msg.ctx_tag = asm_next[63:0]; // see RULE1 RULE22
   assign asm_msg.metadata = asm_next[127:64];
   assign asm_msg.region_id = asm_next[191:128];
   assign asm_msg.region_offset = asm_next[255:192];
   assign asm_msg.region_size = asm_next[319:256];
   assign asm_msg.guest_phys = asm_next[383:320];
   assign asm_msg.host_addr = asm_next[447:384];
   assign asm_msg.events = asm_next[479:448];

   wire push = ping_take & last_word;
   wire pop = state == pem_pkg::PEM_IDLE && count != 4'h0;
   wire store_full = count == 4'(DEPTH);
   wire [4:0] inflight_full = {1'b0, count} + {4'h0, state != pem_pkg::PEM_IDLE};

   assign ping_ready_out = ~store_full; // see RULE9
   assign inflight_out = inflight_full[3:0];
   assign limit_reached_out = {27'h0, inflight_full} >= limit; // see RULE10

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wcnt <= 4'h0;
         asm_buf <= '0;
         wr_ptr <= 3'h0;
         rd_ptr <= 3'h0;
         count <= 4'h0;
      end else begin
         if (ping_take) begin
            asm_buf <= asm_next;
            wcnt <= last_word ? 4'h0 : wcnt + 4'h1;
         end
         if (push) wr_ptr <= wr_ptr + 3'h1;
         if (pop) rd_ptr <= rd_ptr + 3'h1; // see RULE8 RULE18
         count <= count + {3'h0, push} - {3'h0, pop};
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) store[wr_ptr] <= asm_msg; // see RULE9
   end

   // Host address from the device's own region table, guest value discarded
   wire id_ok = cur.region_id < 64'(`PEM_REGIONS);
   wire [2:0] rid = cur.region_id[2:0];
   wire map_ok = id_ok && region_valid[rid];
   wire [63:0] host_res = map_ok ? region_base[rid] + cur.region_offset : 64'h0; // see RULE5
   assign act_out.ctx_tag = cur.ctx_tag;
   assign act_out.metadata = cur.metadata;
   assign act_out.region_offset = cur.region_offset;
   assign act_out.region_size = cur.region_size;
   assign act_out.guest_phys = cur.guest_phys; // see RULE16
   assign act_out.host_addr = host_res; // see RULE11
   assign act_out.host_addr_ok = map_ok;
   assign act_out.events = cur.events;

   assign fence_req_out = state == pem_pkg::PEM_FENCE;
   assign act_valid_out = state == pem_pkg::PEM_ACT;
   assign evt_valid_out = state == pem_pkg::PEM_EVT;
   assign evt_last_out = evt_valid_out && evt_cnt == 2'(`PEM_EVT_WORDS - 1);
   assign evt_data_out = evt_sh[31:0];

   wire fence_on = ctrl[`PEM_CTRL_FENCE_EN] | feat_neg_out[`PEM_FEAT_ORDER_PLAT]; // see RULE19

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= pem_pkg::PEM_IDLE;
         cur <= '0;
         evt_sh <= 96'h0;
         evt_cnt <= 2'h0;
      end else begin
         unique case (state)
            pem_pkg::PEM_IDLE: begin
               if (pop) begin
                  cur <= store[rd_ptr];
                  state <= fence_on ? pem_pkg::PEM_FENCE : pem_pkg::PEM_ACT; // see RULE6
               end
            end
            pem_pkg::PEM_FENCE: begin
               if (fence_ack_in) state <= pem_pkg::PEM_ACT; // see RULE6
            end
            pem_pkg::PEM_ACT: begin
               if (act_done_in) begin
                  evt_sh <= {act_revents_in, cur.ctx_tag}; // see RULE12 RULE23
                  evt_cnt <= 2'h0;
                  state <= (cur.events != 32'h0) ? pem_pkg::PEM_EVT : pem_pkg::PEM_IDLE; // see RULE7
               end
            end
            pem_pkg::PEM_EVT: begin
               if (evt_ready_in) begin
                  evt_sh <= {32'h0, evt_sh[95:32]};
                  evt_cnt <= evt_cnt + 2'h1;
                  if (evt_last_out) state <= pem_pkg::PEM_IDLE;
               end
            end
         endcase
      end
   end

endmodule : pem_unit

// ==== dv/pem_host_model.sv ====
`timescale 1ns/100ps
module pem_host_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic fence_req_in,
   input wire logic act_valid_in,
   input wire pem_pkg::pem_action_t act_in,
   output logic fence_ack_out,
   output logic act_done_out,
   output logic [31:0] act_revents_out
);
   logic [4:0] wait_cnt;
   wire logic busy = (fence_req_in | act_valid_in) & ~fence_ack_out & ~act_done_out;
   wire logic due = wait_cnt >= (slow_in ? 5'h14 : 5'h01);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_cnt <= 5'h00;
         fence_ack_out <= 1'b0;
         act_done_out <= 1'b0;
      end else begin
         fence_ack_out <= fence_req_in & busy & due;
         act_done_out <= act_valid_in & ~fence_req_in & busy & due;
         wait_cnt <= (busy & ~due) ? wait_cnt + 5'h01 : 5'h00;
      end
   end
   // Outside a completion the answer lines show junk
   assign act_revents_out = act_done_out ? act_in.events ^ 32'h8000_0000 : ~act_in.events;
endmodule : pem_host_model

// ==== dv/pem_unit_assertions.sv ====
`timescale 1ns/100ps
module pem_unit_assertions #(
   parameter bit IS_PCI = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic avs_waitrequest_out,
   input wire logic ping_ready_out,
   input wire logic fence_req_out,
   input wire logic fence_ack_in,
   input wire logic act_valid_out,
   input wire pem_pkg::pem_action_t act_out,
   input wire logic act_done_in,
   input wire logic [31:0] act_revents_in,
   input wire logic evt_valid_out,
   input wire logic [31:0] evt_data_out,
   input wire logic evt_last_out,
   input wire logic evt_ready_in,
   input wire logic [63:0] feat_neg_out,
   input wire logic [3:0] inflight_out,
   input wire logic [15:0] notify_queue_out,
   input wire logic notify_pulse_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [1:0] word_cnt;
   logic [63:0] tag_q;
   logic [31:0] rev_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         word_cnt <= 2'h0;
         tag_q <= 64'h0;
         rev_q <= 32'h0;
      end else begin
         if (act_valid_out && act_done_in) begin
            tag_q <= act_out.ctx_tag;
            rev_q <= act_revents_in;
         end
         if (evt_valid_out && evt_ready_in)
            word_cnt <= evt_last_out ? 2'h0 : word_cnt + 2'h1;
      end
   end
   wire logic done = act_valid_out && act_done_in;
   property p_evt_req;
      done && act_out.events != 32'h0 |=> evt_valid_out && word_cnt == 2'h0;
   endproperty
   a_evt_req: assert property (p_evt_req) else $error("no completion");
   property p_evt_none;
      done && act_out.events == 32'h0 |=> !evt_valid_out [*2];
   endproperty
   a_evt_none: assert property (p_evt_none) else $error("spurious completion");
   property p_hold;
      evt_valid_out && !evt_ready_in |=> evt_valid_out && $stable(evt_data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("completion word dropped");
   property p_tag;
      evt_valid_out && word_cnt < 2'h2 |-> !evt_last_out &&
         evt_data_out == (word_cnt[0] ? tag_q[63:32] : tag_q[31:0]);
   endproperty
   a_tag: assert property (p_tag) else $error("completion tag wrong");
   property p_rev;
      evt_valid_out && word_cnt == 2'h2 |-> evt_last_out && evt_data_out == rev_q;
   endproperty
   a_rev: assert property (p_rev) else $error("returned events wrong");
   property p_host;
      act_valid_out && !act_out.host_addr_ok |-> act_out.host_addr == 64'h0;
   endproperty
   a_host: assert property (p_host) else $error("unresolved host address used");
   property p_fence;
      fence_req_out && !fence_ack_in |=> fence_req_out && !act_valid_out;
   endproperty
   a_fence: assert property (p_fence) else $error("acted before fence done");
   property p_ready;
      !ping_ready_out |-> inflight_out >= 4'h8;
   endproperty
   a_ready: assert property (p_ready) else $error("refused with room left");
   property p_notify;
      avs_write_in && !avs_waitrequest_out && avs_address_in[7:2] == 6'h0B |=> notify_pulse_out &&
         {16'h0, notify_queue_out} == ($past(avs_writedata_in) & 32'h0000_FFFF);
   endproperty
   a_notify: assert property (p_notify) else $error("notify lost");
   property p_sriov;
      feat_neg_out[37] |-> IS_PCI;
   endproperty
   a_sriov: assert property (p_sriov) else $error("virtualization bit on non-pci");
   c_fence: cover property (fence_req_out && fence_ack_in);
   c_evt: cover property (evt_valid_out && evt_last_out && evt_ready_in);
   c_full: cover property (!ping_ready_out);
endmodule : pem_unit_assertions
bind pem_unit pem_unit_assertions #(.IS_PCI(IS_PCI)) chk (.clk_in, .rst_n_in, .avs_address_in,
   .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .ping_ready_out, .fence_req_out,
   .fence_ack_in, .act_valid_out, .act_out, .act_done_in, .act_revents_in, .evt_valid_out,
   .evt_data_out, .evt_last_out, .evt_ready_in, .feat_neg_out, .inflight_out, .notify_queue_out,
   .notify_pulse_out);

// ==== dv/ping_event_message_unit_tb_top.sv ====
`timescale 1ns/100ps
module ping_event_message_unit_tb_top;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic ping_valid_in = 1'b0;
   logic [31:0] ping_data_in = 32'h0;
   logic evt_ready_in = 1'b0;
   logic slow = 1'b0;
   logic [31:0] avs_readdata_out, act_revents_in, evt_data_out;
   logic avs_waitrequest_out, ping_ready_out, fence_req_out, fence_ack_in, act_valid_out, act_done_in;
   logic evt_valid_out, evt_last_out, notify_pulse_out, limit_reached_out;
   pem_pkg::pem_action_t act_out;
   logic [63:0] feat_neg_out;
   logic [3:0] inflight_out;
   logic [15:0] notify_queue_out, notify_data_out;
   logic [31:0] rnd = 32'h0000_8B49;
   logic [31:0] rs = 32'h0000_8B49;
   logic [31:0] rq[$];
   logic [32:0] eq[$];
   logic [63:0] aq[$];
   int miscompares = 0;
   int total_checks = 0;
   int full_seen = 0;
   pem_unit uut (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
      .avs_readdata_out, .avs_waitrequest_out, .ping_valid_in, .ping_data_in, .ping_ready_out,
      .fence_req_out, .fence_ack_in, .act_valid_out, .act_out, .act_done_in, .act_revents_in,
      .evt_valid_out, .evt_data_out, .evt_last_out, .evt_ready_in, .feat_neg_out, .inflight_out,
      .limit_reached_out, .notify_queue_out, .notify_data_out, .notify_pulse_out);
   pem_host_model host (.clk_in, .rst_n_in, .slow_in(slow), .fence_req_in(fence_req_out),
      .act_valid_in(act_valid_out), .act_in(act_out), .fence_ack_out(fence_ack_in),
      .act_done_out(act_done_in), .act_revents_out(act_revents_in));
   initial forever #20 clk_in = ~clk_in;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict(input bit hung);
      if (hung) miscompares++;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= ~wr;
      avs_write_in <= wr;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      if (n >= 50) give_verdict(1'b1);
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic trig(input logic [63:0] tg, input logic [31:0] rid, off, ev, input logic [63:0] hx);
      logic [31:0] w[15];
      int n;
      rnd = xs(rnd);
      w = '{tg[31:0], tg[63:32], rnd, rnd, rid, 32'h0, off, 32'h0, 32'h40, 32'h0, off, 32'h0, ~rnd, rnd, ev};
      aq.push_back(hx);
      if (ev != 32'h0) begin
         eq.push_back({1'b0, tg[31:0]});
         eq.push_back({1'b0, tg[63:32]});
         eq.push_back({1'b1, ev ^ 32'h8000_0000});
      end
      @(posedge clk_in);
      n = 0;
      while (limit_reached_out === 1'b1 && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 3000) give_verdict(1'b1);
      for (int i = 0; i < 15; i++) begin
         ping_valid_in <= 1'b1;
         ping_data_in <= w[i];
         n = 0;
         do begin
            @(posedge clk_in);
            n++;
         end while (ping_ready_out !== 1'b1 && n < 3000);
         if (n >= 3000) give_verdict(1'b1);
      end
      ping_valid_in <= 1'b0;
   endtask : trig
   always @(posedge clk_in) begin
      rs <= xs(rs);
      evt_ready_in <= rs[0] | rs[1];
   end
   always @(posedge clk_in) begin
      if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) chk(avs_readdata_out, rq.pop_front());
      if (evt_valid_out === 1'b1 && evt_ready_in) chk({evt_last_out, evt_data_out}, eq.pop_front());
      if (ping_ready_out === 1'b0) full_seen++;
      if (inflight_out === 4'h9) chk(limit_reached_out, 1'b1);
      if (act_valid_out === 1'b1 && act_done_in === 1'b1) chk(act_out.host_addr, aq.pop_front());
   end
   initial begin
      int n;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(8'h00, 32'h3000_0000);
      rd(8'h04, 32'h0000_005F);
      rd(8'h10, 32'h0000_0001);
      rd(8'h18, 32'h0000_0008);
      rd(8'h14, 32'h0000_0010);
      rd(8'h40, 32'h0000_0000);
      bus(1'b1, 8'h04, 32'h0000_0000);
      rd(8'h04, 32'h0000_005F);
      bus(1'b1, 8'h08, 32'hFFFF_FFFF);
      bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
      @(negedge clk_in);
      chk(feat_neg_out, 64'h0000_005F_3000_0000);
      bus(1'b1, 8'h2C, 32'hABCD_1234);
      rd(8'h30, 32'hABCD_1234);
      chk({notify_data_out, notify_queue_out}, 32'hABCD_1234);
      bus(1'b1, 8'h0C, 32'h0000_0000);
      bus(1'b1, 8'h2C, 32'h5555_1234);
      rd(8'h30, 32'h0000_1234);
      chk({notify_data_out, notify_queue_out}, 32'h0000_1234);
      bus(1'b1, 8'h1C, 32'h0000_0001);
      bus(1'b1, 8'h20, 32'h1000_0000);
      bus(1'b1, 8'h24, 32'h0000_0002);
      bus(1'b1, 8'h28, 32'h0000_0002);
      trig(64'hA5A5_0001_0000_0011, 32'h1, 32'h100, 32'h5, 64'h0000_0002_1000_0100);
      trig(64'hA5A5_0002_0000_0022, 32'h2, 32'h100, 32'h0, 64'h0);
      trig(64'hA5A5_0003_0000_0033, 32'h9, 32'h0, 32'h1, 64'h0);
      bus(1'b1, 8'h10, 32'h0000_0000);
      bus(1'b1, 8'h18, 32'h0000_0009);
      rd(8'h18, 32'h0000_0009);
      slow <= 1'b1;
      for (int i = 0; i < 30; i++) begin
         trig({32'hC0DE_0000, 31'h0, i[0]}, 32'h9, rnd, rnd & 32'h0000_0003, 64'h0);
      end
      slow <= 1'b0;
      n = 0;
      while ((inflight_out !== 4'h0 || eq.size() != 0) && n < 5000) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 5000) give_verdict(1'b1);
      chk(aq.size() + rq.size(), 0);
      chk(full_seen != 0, 1'b1);
      give_verdict(1'b0);
   end
endmodule : ping_event_message_unit_tb_top
